// [bldc_pkg.sv]
// shared constants, enumerations and state records for the motor sequencer
package bldc_pkg;
	// ----------------------------------------
	// clock and bus geometry
	// ----------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int ADC_W = 12;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_TARGET = 6'h04;
	localparam logic [5:0] REG_ACTUAL = 6'h08;
	localparam logic [5:0] REG_GAIN = 6'h0C;
	localparam logic [5:0] REG_PERIOD = 6'h10;
	localparam logic [5:0] REG_DEAD = 6'h14;
	localparam logic [5:0] REG_STATUS = 6'h18;
	localparam logic [5:0] REG_DUTY = 6'h1C;
	localparam logic [5:0] REG_BUS_MEAS = 6'h20;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int ST_PHASE_LSB = 0;
	localparam int ST_HALT = 2;
	localparam int ST_POS_LSB = 4;
	localparam int ST_DUTY_APPLIED = 8;
	localparam int ST_MEAS_DONE = 9;
	localparam int ST_WROTE_A = 10;
	localparam int ST_WROTE_B = 11;
	localparam int ST_COMM_HOLD = 12;
	localparam int GAIN_KI_LSB = 16;
	localparam int MEAS_CURR_LSB = 16;
	localparam logic [7:0] START_FLAG_RUN = 8'h01;
	localparam logic [15:0] PERIOD_RST = 16'h0FA0;
	localparam logic [15:0] DEAD_RST = 16'h0032;
	localparam logic [15:0] KP_RST = 16'h0100;
	localparam logic [15:0] KI_RST = 16'h0010;
	localparam int PI_SHIFT = 8;
	// ----------------------------------------
	// timing and channel selection
	// ----------------------------------------
	localparam int HALL_SETTLE_CYCLES = 10;
	localparam logic [3:0] ADC_CH_VOLT = 4'h3;
	localparam logic [3:0] ADC_CH_CURR = 4'h4;
	localparam logic [1:0] PH_A = 2'h0;
	localparam logic [1:0] PH_B = 2'h1;
	localparam logic [1:0] PH_C = 2'h2;
	localparam logic [1:0] PH_NONE = 2'h3;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		init_phase = 2'b00,
		stop_phase = 2'b01,
		start_phase = 2'b10,
		run_phase = 2'b11
	} app_phase_e;
	typedef enum logic [1:0] {
		seq_idle = 2'b00,
		seq_volt = 2'b01,
		seq_curr = 2'b10
	} meas_state_e;
	typedef struct packed {
		logic [ADC_W-1:0] volt;
		logic [ADC_W-1:0] curr;
	} bus_meas_s;
	typedef struct packed {
		logic [2:0] prev;
		logic busy;
		logic [3:0] cnt;
		logic [2:0] code;
		logic valid;
	} hall_state_s;
	typedef struct packed {
		meas_state_e st;
		logic trig_s1;
		logic trig_s2;
		logic trig_s3;
		logic start;
		logic [3:0] chan;
		logic [ADC_W-1:0] volt_tmp;
		bus_meas_s result;
		logic done;
	} meas_state_s;
	typedef struct packed {
		app_phase_e phase;
		logic halt;
		logic [7:0] start_flag;
		logic [15:0] target;
		logic [15:0] actual;
		logic [15:0] kp;
		logic [15:0] ki;
		logic [15:0] period;
		logic [15:0] dead;
		logic [15:0] count;
		logic [15:0] match_a;
		logic [15:0] match_b;
		logic [15:0] reload_a;
		logic [15:0] reload_b;
		logic wrote_a;
		logic wrote_b;
		logic upd_pend;
		logic duty_applied;
		logic meas_done;
		logic signed [33:0] integ;
		logic comm_hold;
		logic [2:0] pos;
		logic [1:0] hi_ph;
		logic [1:0] lo_ph;
		logic [5:0] gate;
		logic adc_trig;
		logic comm_evt;
		logic ack;
		logic [31:0] rdata;
	} main_state_s;
endpackage

// [hall_position.sv]
// hall edge detector and settled rotor position sampler
`timescale 1ns/1ps
module hall_position import bldc_pkg::*; (
	input wire logic clk_sys, // system clock
	input wire logic reset, // synchronous reset, high
	input wire logic [2:0] hall_in, // hall lines a, b, c
	output logic edge_pulse, // any hall edge seen
	output logic pos_valid, // position sampled, one cycle
	output logic [2:0] pos_code // rotor position code
);
	localparam logic [3:0] SETTLE_LAST = 4'(HALL_SETTLE_CYCLES - 1);
	hall_state_s state_reg;
	hall_state_s state_next;
	logic edge_seen;
	logic [4:0] quiet_cnt;

	assign edge_seen = hall_in != state_reg.prev;
	assign edge_pulse = edge_seen;
	assign pos_valid = state_reg.valid;
	assign pos_code = state_reg.code;

	always_comb begin
		state_next = state_reg;
		state_next.prev = hall_in;
		state_next.valid = 1'b0;
		if (edge_seen) begin
			state_next.busy = 1'b1; // RULE13
			state_next.cnt = 4'h0;
		end else if (state_reg.busy) begin
			state_next.cnt = state_reg.cnt + 4'h1;
			if (state_reg.cnt == SETTLE_LAST) begin
				state_next.busy = 1'b0; // RULE11
				state_next.valid = 1'b1;
				state_next.code = {hall_in[2], hall_in[1], hall_in[0]}; // RULE10
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// cycles since the last hall edge, saturating; helper for the settle check
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			quiet_cnt <= 5'h00;
		end else if (edge_seen) begin
			quiet_cnt <= 5'h01;
		end else if (quiet_cnt != 5'h00 && quiet_cnt != 5'h1F) begin
			quiet_cnt <= quiet_cnt + 5'h01;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_settle_then_sample: assert property (quiet_cnt == 5'(HALL_SETTLE_CYCLES) && !edge_seen |=> pos_valid) // RULE11
		else $error("position not sampled after settling");
	chk_code_bit_order: assert property (state_reg.busy && !edge_seen && state_reg.cnt == SETTLE_LAST
		|=> pos_code == $past(hall_in)) // RULE10
		else $error("position code does not match hall lines");
	cov_settled_read: cover property (edge_seen ##11 pos_valid);
endmodule

// [meas_sequence.sv]
// bus voltage and current conversion sequence driven by the timer trigger
`timescale 1ns/1ps
module meas_sequence import bldc_pkg::*; (
	input wire logic clk_sys, // system clock
	input wire logic reset, // synchronous reset, high
	input wire logic seq_enable, // sequence enable
	input wire logic trig_level, // timer trigger output level
	output logic adc_start, // conversion request, one cycle
	output logic [3:0] adc_channel, // channel of the request
	input wire logic adc_done, // conversion finished, one cycle
	input wire logic [ADC_W-1:0] adc_data, // conversion result
	output bus_meas_s result, // published pair of results
	output logic seq_done // whole sequence finished, one cycle
);
	meas_state_s state_reg;
	meas_state_s state_next;
	logic trig_rise;

	// positive edge taken after the synchroniser stages
	assign trig_rise = state_reg.trig_s2 && !state_reg.trig_s3; // RULE2
	assign adc_start = state_reg.start;
	assign adc_channel = state_reg.chan;
	assign result = state_reg.result;
	assign seq_done = state_reg.done;

	always_comb begin
		state_next = state_reg;
		state_next.trig_s1 = trig_level;
		state_next.trig_s2 = state_reg.trig_s1;
		state_next.trig_s3 = state_reg.trig_s2;
		state_next.start = 1'b0;
		state_next.done = 1'b0;
		unique case (state_reg.st)
			seq_idle: begin
				// only the hardware trigger starts a sequence; no burst, no single step
				if (seq_enable && trig_rise) begin
					state_next.st = seq_volt; // RULE1
					state_next.start = 1'b1;
					state_next.chan = ADC_CH_VOLT;
				end
			end
			seq_volt: begin
				if (adc_done) begin
					state_next.volt_tmp = adc_data;
					state_next.st = seq_curr; // RULE1
					state_next.start = 1'b1;
					state_next.chan = ADC_CH_CURR;
				end
			end
			seq_curr: begin
				if (adc_done) begin
					state_next.result.volt = state_reg.volt_tmp; // RULE3
					state_next.result.curr = adc_data;
					state_next.done = 1'b1; // RULE15
					state_next.st = seq_idle;
				end
			end
			default: begin
				state_next.st = seq_idle;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_start_needs_trigger: assert property (adc_start && adc_channel == ADC_CH_VOLT
		|-> $past(trig_rise) && $past(state_reg.st == seq_idle)) // RULE1
		else $error("sequence started without hardware trigger");
	chk_report_at_end: assert property ($changed(result) |-> $past(state_reg.st == seq_curr) && seq_done) // RULE3
		else $error("results published before sequence end");
	chk_curr_follows_volt: assert property (state_reg.st == seq_volt && adc_done
		|=> adc_start && adc_channel == ADC_CH_CURR) // RULE1
		else $error("current channel not converted after voltage");
	cov_full_sequence: cover property (trig_rise ##1 adc_start ##[1:50] seq_done);
endmodule

// [bldc_hall_pwm_sequencer.sv]
// brushless motor sequencer: phases, pi duty loop, pwm timer, commutation, bus slave
// ----------------------------------------
// Notes on behaviour
// [RULE1] measurement starts only on timer output seven
// [RULE2] rising trigger edge, synchronised, no burst/step
// [RULE3] results reported once at sequence end
// [RULE4] reset enters init, clears, configures, then stop
// [RULE5] stop moves to start only when flag is 1
// [RULE6] start clears halt, then enters run
// [RULE7] run computes speed error, pi, duty
// [RULE8] duty complete after both reloads written
// [RULE9] run with flag 0 returns to init
// [RULE10] position code is a b c, msb first
// [RULE11] settle ten cycles before sampling hall
// [RULE12] gates on outputs 0,1,2,3,5,6 only
// [RULE13] hall edge stops, zeroes counter, commutates
// [RULE14] second edge equals first plus dead time
// [RULE15] sequence completion raises measurement event
// [RULE16] reloads transfer only at period limit
// [RULE17] codes 000 and 111 drive nothing
// ----------------------------------------
`timescale 1ns/1ps
module bldc_hall_pwm_sequencer import bldc_pkg::*; (
	input wire logic clk_sys, // system clock, 125 MHz
	input wire logic reset, // synchronous reset, high
	input wire logic [ADDR_W-1:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [DATA_W-1:0] avs_writedata, // write data
	output logic [DATA_W-1:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic [2:0] hall_in, // hall lines a, b, c
	output logic [5:0] gate_drive, // timer outputs 0,1,2,3,5,6
	output logic adc_trigger_output, // timer output 7
	output logic commutation_event, // hall edge event, one cycle
	output logic adc_start, // conversion request
	output logic [3:0] adc_channel, // conversion channel
	input wire logic adc_done, // conversion finished
	input wire logic [ADC_W-1:0] adc_data, // conversion result
	output logic meas_done_event // measurement sequence complete, one cycle
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// six-step pair for a position code: {high-switching phase, grounded phase}
	function automatic logic [3:0] six_step(input logic [2:0] code);
		unique case (code)
			3'b101: six_step = {PH_A, PH_B};
			3'b100: six_step = {PH_A, PH_C};
			3'b110: six_step = {PH_B, PH_C};
			3'b010: six_step = {PH_B, PH_A};
			3'b011: six_step = {PH_C, PH_A};
			3'b001: six_step = {PH_C, PH_B};
			default: six_step = {PH_NONE, PH_NONE}; // RULE17
		endcase
	endfunction

	main_state_s state_reg;
	main_state_s state_next;
	logic hall_edge;
	logic pos_valid;
	logic [2:0] pos_code;
	logic seq_done;
	bus_meas_s meas;
	logic running;
	logic limit;
	logic pwm_top;
	logic pwm_bot;
	logic [5:0] gate_calc;
	logic wr_hit;
	logic signed [16:0] err;
	logic signed [33:0] p_term;
	logic signed [33:0] i_term;
	logic signed [33:0] pi_sum;
	logic signed [33:0] pi_shift;
	logic [15:0] duty_max;
	logic [15:0] duty;
	logic duty_sat;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	hall_position u_hall (
		.clk_sys(clk_sys),
		.reset(reset),
		.hall_in(hall_in),
		.edge_pulse(hall_edge),
		.pos_valid(pos_valid),
		.pos_code(pos_code)
	);

	meas_sequence u_meas (
		.clk_sys(clk_sys),
		.reset(reset),
		.seq_enable(!state_reg.halt),
		.trig_level(state_reg.adc_trig),
		.adc_start(adc_start),
		.adc_channel(adc_channel),
		.adc_done(adc_done),
		.adc_data(adc_data),
		.result(meas),
		.seq_done(seq_done)
	);

	// ----------------------------------------
	// pwm timer and pi arithmetic
	// ----------------------------------------
	assign running = !state_reg.halt && !state_reg.comm_hold;
	assign limit = running && state_reg.count == state_reg.period - 16'h0001;
	// edge-aligned pair: top between dead time and edge a, bottom after edge b
	assign pwm_top = running && state_reg.count >= state_reg.dead && state_reg.count < state_reg.match_a;
	assign pwm_bot = running && state_reg.count >= state_reg.match_b;

	always_comb begin
		gate_calc = 6'h00;
		if (state_reg.hi_ph != PH_NONE && state_reg.lo_ph != PH_NONE) begin
			gate_calc[{state_reg.hi_ph, 1'b0}] = pwm_top; // RULE12
			gate_calc[{state_reg.hi_ph, 1'b1}] = pwm_bot;
			gate_calc[{state_reg.lo_ph, 1'b1}] = running;
		end
	end

	always_comb begin
		err = $signed({1'b0, state_reg.target}) - $signed({1'b0, state_reg.actual}); // RULE7
		p_term = $signed({1'b0, state_reg.kp}) * err;
		i_term = $signed({1'b0, state_reg.ki}) * err;
		pi_sum = p_term + state_reg.integ;
		pi_shift = pi_sum >>> PI_SHIFT;
		duty_max = state_reg.period - state_reg.dead - 16'h0001;
		duty_sat = 1'b1;
		if (pi_shift < 34'sh0) begin
			duty = 16'h0000;
		end else if (pi_shift > $signed({18'h0, duty_max})) begin
			duty = duty_max;
		end else begin
			duty = pi_shift[15:0];
			duty_sat = 1'b0;
		end
	end

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			REG_CTRL: rd_mux = {24'h0, state_reg.start_flag};
			REG_TARGET: rd_mux = {16'h0, state_reg.target};
			REG_ACTUAL: rd_mux = {16'h0, state_reg.actual};
			REG_GAIN: rd_mux = {state_reg.ki, state_reg.kp};
			REG_PERIOD: rd_mux = {16'h0, state_reg.period};
			REG_DEAD: rd_mux = {16'h0, state_reg.dead};
			REG_STATUS: begin
				rd_mux[ST_PHASE_LSB +: 2] = state_reg.phase;
				rd_mux[ST_HALT] = state_reg.halt;
				rd_mux[ST_POS_LSB +: 3] = state_reg.pos;
				rd_mux[ST_DUTY_APPLIED] = state_reg.duty_applied;
				rd_mux[ST_MEAS_DONE] = state_reg.meas_done;
				rd_mux[ST_WROTE_A] = state_reg.wrote_a;
				rd_mux[ST_WROTE_B] = state_reg.wrote_b;
				rd_mux[ST_COMM_HOLD] = state_reg.comm_hold;
			end
			REG_DUTY: rd_mux = {state_reg.match_b, state_reg.match_a};
			REG_BUS_MEAS: rd_mux = {4'h0, meas.curr, 4'h0, meas.volt};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	assign wr_hit = avs_write && state_reg.ack;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.ack = (avs_read || avs_write) && !state_reg.ack;
		if ((avs_read || avs_write) && !state_reg.ack) begin
			state_next.rdata = rd_mux;
		end
		state_next.comm_evt = hall_edge;
		state_next.adc_trig = running && state_reg.count >= state_reg.match_a && state_reg.count < state_reg.match_b;
		state_next.gate = gate_calc;
		// pwm counter, period limit and double-buffered duty
		if (running) begin
			state_next.count = limit ? 16'h0000 : state_reg.count + 16'h0001;
		end
		if (limit && state_reg.wrote_a && state_reg.wrote_b) begin
			state_next.match_a = state_reg.reload_a; // RULE16
			state_next.match_b = state_reg.reload_b;
			state_next.wrote_a = 1'b0;
			state_next.wrote_b = 1'b0;
			state_next.duty_applied = 1'b1; // RULE8
		end
		if (limit && state_reg.phase == run_phase) begin
			state_next.reload_a = duty; // RULE8
			state_next.wrote_a = 1'b1;
			state_next.upd_pend = 1'b1;
			if (!duty_sat) begin
				state_next.integ = state_reg.integ + i_term; // RULE7
			end
		end
		if (state_reg.upd_pend) begin
			state_next.reload_b = state_reg.reload_a + state_reg.dead; // RULE14
			state_next.wrote_b = 1'b1; // RULE8
			state_next.upd_pend = 1'b0;
		end
		// commutation: stop and zero on edge, resume once the position is read
		if (hall_edge) begin
			state_next.count = 16'h0000; // RULE13
			state_next.comm_hold = 1'b1;
			state_next.hi_ph = PH_NONE;
			state_next.lo_ph = PH_NONE;
		end else if (pos_valid) begin
			state_next.pos = pos_code;
			{state_next.hi_ph, state_next.lo_ph} = six_step(pos_code); // RULE17
			state_next.comm_hold = 1'b0;
		end
		// sticky status, a new event wins over the clear
		if (wr_hit && avs_address == REG_STATUS) begin
			if (avs_writedata[ST_DUTY_APPLIED]) begin
				state_next.duty_applied = limit && state_reg.wrote_a && state_reg.wrote_b;
			end
			if (avs_writedata[ST_MEAS_DONE]) begin
				state_next.meas_done = seq_done;
			end
		end
		if (seq_done) begin
			state_next.meas_done = 1'b1; // RULE15
		end
		if (wr_hit) begin
			unique case (avs_address)
				REG_CTRL: state_next.start_flag = avs_writedata[7:0];
				REG_TARGET: state_next.target = avs_writedata[15:0];
				REG_ACTUAL: state_next.actual = avs_writedata[15:0];
				REG_GAIN: {state_next.ki, state_next.kp} = avs_writedata;
				REG_PERIOD: state_next.period = avs_writedata[15:0];
				REG_DEAD: state_next.dead = avs_writedata[15:0];
				default: begin
				end
			endcase
		end
		// application phases
		unique case (state_reg.phase)
			init_phase: begin
				state_next.halt = 1'b1; // RULE4
				state_next.integ = 34'sh0;
				state_next.count = 16'h0000;
				state_next.match_a = 16'h0000;
				state_next.match_b = state_reg.dead;
				state_next.reload_a = 16'h0000;
				state_next.reload_b = state_reg.dead;
				state_next.wrote_a = 1'b0;
				state_next.wrote_b = 1'b0;
				state_next.upd_pend = 1'b0;
				state_next.phase = stop_phase;
			end
			stop_phase: begin
				if (state_reg.start_flag == START_FLAG_RUN) begin
					state_next.phase = start_phase; // RULE5
				end
			end
			start_phase: begin
				state_next.halt = 1'b0; // RULE6
				state_next.phase = run_phase;
			end
			run_phase: begin
				if (state_reg.start_flag == 8'h00) begin
					state_next.phase = init_phase; // RULE9
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= '0;
			state_reg.phase <= init_phase; // RULE4
			state_reg.halt <= 1'b1;
			state_reg.period <= PERIOD_RST;
			state_reg.dead <= DEAD_RST;
			state_reg.match_b <= DEAD_RST;
			state_reg.reload_b <= DEAD_RST;
			state_reg.kp <= KP_RST;
			state_reg.ki <= KI_RST;
			state_reg.hi_ph <= PH_NONE;
			state_reg.lo_ph <= PH_NONE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
	assign avs_readdata = state_reg.rdata;
	assign gate_drive = state_reg.gate;
	assign adc_trigger_output = state_reg.adc_trig;
	assign commutation_event = state_reg.comm_evt;
	assign meas_done_event = seq_done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_init_goes_stop: assert property (!reset && state_reg.phase == init_phase
		|=> state_reg.phase == stop_phase && state_reg.halt) // RULE4
		else $error("init did not move to stop with halt set");
	chk_stop_waits_flag: assert property (state_reg.phase == stop_phase && state_reg.start_flag != START_FLAG_RUN
		|=> state_reg.phase == stop_phase) // RULE5
		else $error("stop left without start flag");
	chk_start_clears_halt: assert property (state_reg.phase == start_phase
		|=> state_reg.phase == run_phase && !state_reg.halt) // RULE6
		else $error("start did not release the timer");
	chk_run_exit_init: assert property (state_reg.phase == run_phase && state_reg.start_flag == 8'h00
		|=> state_reg.phase == init_phase ##1 state_reg.halt) // RULE9
		else $error("run did not return to init");
	chk_edge_b_dead: assert property (state_reg.upd_pend
		|=> state_reg.reload_b == state_reg.reload_a + $past(state_reg.dead) && state_reg.wrote_b) // RULE14
		else $error("second duty edge not first plus dead time");
	chk_match_at_limit: assert property ($changed(state_reg.match_a) || $changed(state_reg.match_b)
		|-> $past(limit) || $past(state_reg.phase == init_phase)) // RULE16
		else $error("match registers changed outside period limit");
	chk_comm_stops_count: assert property (!reset && hall_edge |=> state_reg.count == 16'h0000 && state_reg.comm_hold
		&& commutation_event) // RULE13
		else $error("hall edge did not stop and zero the counter");
	chk_invalid_no_gate: assert property (pos_valid && !hall_edge && (pos_code == 3'b000 || pos_code == 3'b111)
		|=> ##1 gate_drive == 6'h00) // RULE17
		else $error("invalid hall code drove gates");
	chk_duty_both_written: assert property ($rose(state_reg.duty_applied) |-> $past(state_reg.wrote_a)
		&& $past(state_reg.wrote_b)) // RULE8
		else $error("duty applied before both reloads written");
	chk_pair_exclusive: assert property (!(gate_drive[0] && gate_drive[1]) && !(gate_drive[2] && gate_drive[3])
		&& !(gate_drive[4] && gate_drive[5])) // RULE14
		else $error("complementary gates on together");
	chk_meas_sticky: assert property (seq_done |=> state_reg.meas_done) // RULE15
		else $error("measurement event not recorded");
	cov_start_to_run: cover property (state_reg.phase == stop_phase ##1 state_reg.phase == start_phase
		##1 state_reg.phase == run_phase);
	cov_duty_transfer: cover property (limit && state_reg.wrote_a && state_reg.wrote_b);
	cov_commutation: cover property (hall_edge ##[1:20] pos_valid);
endmodule

// [adc_model.sv]
// bus adc model answering conversion requests after a latency
`timescale 1ns/1ps
module adc_model import bldc_pkg::*; #(
	parameter int LAT = 5 // result arrives LAT + 1 cycles after the request cycle
) (
	input wire logic clk_sys, // system clock
	input wire logic reset, // synchronous reset, high
	input wire logic adc_start, // conversion request
	input wire logic [3:0] adc_channel, // requested channel
	output logic adc_done, // result ready, one cycle
	output logic [ADC_W-1:0] adc_data // result, valid with done
);
	int cnt;
	logic [3:0] ch;
	// data outside the done cycle toggles so a stale sample never matches
	always @(posedge clk_sys) begin
		if (reset) begin
			cnt <= 0;
			adc_done <= 1'b0;
			adc_data <= 12'h000;
		end else if (adc_start) begin
			cnt <= LAT;
			ch <= adc_channel;
			adc_done <= 1'b0;
			adc_data <= ~adc_data;
		end else if (cnt == 1) begin
			cnt <= 0;
			adc_done <= 1'b1;
			adc_data <= {8'hA5, ch};
		end else begin
			if (cnt > 1) cnt <= cnt - 1;
			adc_done <= 1'b0;
			adc_data <= ~adc_data;
		end
	end
endmodule

// [bldc_hall_pwm_sequencer_tb.sv]
// self-checking bench for the motor sequencer
`timescale 1ns/1ps
module bldc_hall_pwm_sequencer_tb import bldc_pkg::*; ;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic [31:0] q;
	logic avs_waitrequest;
	logic [2:0] hall_in = 3'h5;
	logic [5:0] gate_drive;
	logic adc_trigger_output, commutation_event, adc_start, adc_done, meas_done_event;
	logic [3:0] adc_channel;
	logic [ADC_W-1:0] adc_data;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	always #4 clk_sys = ~clk_sys;
	bldc_hall_pwm_sequencer DUT (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .hall_in, .gate_drive, .adc_trigger_output, .commutation_event,
		.adc_start, .adc_channel, .adc_done, .adc_data, .meas_done_event);
	adc_model #(.LAT(5)) adc (.clk_sys, .reset, .adc_start, .adc_channel, .adc_done, .adc_data);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task automatic wait_hi(ref logic s, input int n);
		for (int i = 0; i < n && s !== 1'b1; i++) @(negedge clk_sys);
		chk(32'(s), 32'h1);
	endtask
	task print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		rd(REG_STATUS, 32'h7, 32'h5);
		rd(REG_GAIN, 32'hFFFFFFFF, {KI_RST, KP_RST});
		rd(6'h3C, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, REG_CTRL, 32'h2);
		rd(REG_STATUS, 32'h7, 32'h5);
		bus(1'b1, REG_CTRL, 32'h1);
		repeat (2) @(posedge clk_sys);
		rd(REG_STATUS, 32'h7, 32'h3);
		hall_in <= 3'h4;
		wait_hi(commutation_event, 5);
		repeat (15) @(posedge clk_sys);
		rd(REG_STATUS, 32'h70, 32'h40);
		chk(32'(gate_drive[5]), 32'h1);
		wait_hi(adc_trigger_output, 100);
		wait_hi(meas_done_event, 20000);
		repeat (2 * PERIOD_RST + 64) @(posedge clk_sys);
		rd(REG_BUS_MEAS, 32'hFFFFFFFF, {16'h0A54, 16'h0A53});
		rd(REG_DUTY, 32'hFFFFFFFF, {DEAD_RST, 16'h0000});
		rd(REG_STATUS, 32'h300, 32'h300);
		hall_in <= 3'h7;
		repeat (20) @(posedge clk_sys);
		chk(32'(gate_drive), 32'h0);
		bus(1'b1, REG_CTRL, 32'h0);
		repeat (2) @(posedge clk_sys);
		rd(REG_STATUS, 32'h7, 32'h5);
		print_verdict;
	end
endmodule
